// ---- dsb_pkg.sv ----
// Shared constants for the burst-of-two DDR memory port and its master
// Operation
// (R1) Address and controls captured on true rising edge
// (R2) Write words on true then complementary edges
// (R3) Master lowers load with address and direction
// (R4) Every access moves exactly two words
// (R5) Select high reads, low writes when loading
// (R6) Lowest address bit is burst bit zero
// (R7) Address ignored when deselected or mid burst
// (R8) Low lane strobe writes lane, both edges
// (R9) Wide organisation: four nine-bit lanes
// (R10) Organisations: 1M x 18 or 512K x 36
// (R11) Read words launched on output clock edges
// (R12) Output clocks high: read timed by input clocks
// (R13) Tied-high output clocks never toggle
// (R14) Second word uses address bit zero inverted
// (R15) Read of posted write returns held data
// (R16) Idle cycle needed between read and write
// (R17) Narrow organisation: two nine-bit lanes
// (R18) Idle load releases bus, no access
package dsb_pkg;
    // Organisation defaults: 1M x 18, the other is 19 bits by 36
    localparam int DEF_DATA_W = 18;
    localparam int DEF_ADDR_W = 20;
    localparam int WIDE_DATA_W = 36;
    localparam int WIDE_ADDR_W = 19;
    localparam int LANE_W = 9;
    localparam int BURST_LEN = 2;
    // Master side timing: clock period in ns, read slots in system clock cycles, buffer depth in words
    localparam int CLK_PERIOD_NS = 10;
    localparam int RD_FIRST_SLOT = 3;
    localparam int RD_PIPE_LEN = 5;
    localparam int RD_BUF_DEPTH = 2;
    // Bus pins idle level
    localparam logic IDLE_LOAD_N = 1'h1;
endpackage

// ---- dsb_link_if.sv ----
// Pin-level link between the memory port and its bus master
`timescale 1ns/100ps
interface dsb_link_if #(
    parameter int DATA_W = dsb_pkg::DEF_DATA_W,
    parameter int ADDR_W = dsb_pkg::DEF_ADDR_W
);
    localparam int LANES = DATA_W / dsb_pkg::LANE_W;

    logic                kTrue;
    logic                kComp;
    logic                cTrue;
    logic                cComp;
    logic                loadStrobeN;
    logic                readWriteSel;
    logic [ADDR_W-1:1]   addressIn;
    logic                addressBitZero;
    logic [LANES-1:0]    byteLaneWriteN;
    logic [DATA_W-1:0]   masterDq;
    logic                masterDqOe;
    logic [DATA_W-1:0]   deviceDq;
    logic                deviceDqOe;
    logic [DATA_W-1:0]   dq;
    logic                echoClockTrue;
    logic                echoClockComp;

    // Shared data wire; an undriven bus reads as zero
    assign dq = deviceDqOe ? deviceDq : (masterDqOe ? masterDq : '0);

    modport master (
        output kTrue, kComp, cTrue, cComp, loadStrobeN, readWriteSel,
        output addressIn, addressBitZero, byteLaneWriteN, masterDq, masterDqOe,
        input  dq, echoClockTrue, echoClockComp
    );
    modport device (
        input  kTrue, kComp, cTrue, cComp, loadStrobeN, readWriteSel,
        input  addressIn, addressBitZero, byteLaneWriteN, dq,
        output deviceDq, deviceDqOe, echoClockTrue, echoClockComp
    );
endinterface

// ---- dsb_sram_device.sv ----
// Memory end: command capture, posted write, bypass and DDR read output
`timescale 1ns/100ps
module dsb_sram_device #(
    parameter int DATA_W = dsb_pkg::DEF_DATA_W,
    parameter int ADDR_W = dsb_pkg::DEF_ADDR_W
) (
    input  wire logic  clock,
    input  wire logic  reset,
    dsb_link_if.device link,
    output logic       burstBusy
);
    import dsb_pkg::*;

    localparam int LANES = DATA_W / LANE_W; // R10
    localparam int DEPTH = 1 << ADDR_W;

    typedef enum logic {DSB_IDLE, DSB_WR_SECOND} dsb_burst_e;

    // Lanes with a low strobe take the new data
    function automatic logic [DATA_W-1:0] mergeLanes(
        input logic [DATA_W-1:0] oldWord,
        input logic [DATA_W-1:0] newWord,
        input logic [LANES-1:0]  laneN
    );
        logic [DATA_W-1:0] res;
        res = oldWord;
        for (int i = 0; i < DATA_W; i++) begin
            if (!laneN[i / LANE_W]) begin
                res[i] = newWord[i];
            end
        end
        return res;
    endfunction

    logic [DATA_W-1:0] memArray [DEPTH];
    dsb_burst_e        state_r;
    logic              kTruePrev_r;
    logic              kCompPrev_r;
    logic              cTruePrev_r;
    logic              cCompPrev_r;
    logic              pendValid_r;
    logic [ADDR_W-1:1] pendHi_r;
    logic              pendB0_r;
    logic [DATA_W-1:0] pendWord0_r;
    logic [DATA_W-1:0] pendWord1_r;
    logic [LANES-1:0]  pendLane0_r;
    logic [LANES-1:0]  pendLane1_r;
    logic              rdHoldValid_r;
    logic [DATA_W-1:0] rdHold0_r;
    logic [DATA_W-1:0] rdHold1_r;
    logic [DATA_W-1:0] rdSecond_r;
    logic              secondDue_r;
    logic [DATA_W-1:0] dqOut_r;
    logic              dqOe_r;
    logic              echoTrue_r;
    logic              echoComp_r;
    logic              busy_r;

    // Edge detection of the clock pins; the pins are driven on this clock
    wire kRise = link.kTrue & ~kTruePrev_r;
    wire kcRise = link.kComp & ~kCompPrev_r;
    wire cRise = link.cTrue & ~cTruePrev_r;
    wire ccRise = link.cComp & ~cCompPrev_r;
    wire useInClk = link.cTrue & link.cComp; // R12
    wire outEdge0 = useInClk ? kRise : cRise; // R11
    wire outEdge1 = useInClk ? kcRise : ccRise; // R11

    // Loads are seen only on the true input edge
    wire loadNow = kRise & ~link.loadStrobeN; // R1 R7
    wire readLoad = loadNow & link.readWriteSel; // R5
    wire writeLoad = loadNow & ~link.readWriteSel; // R5
    wire commitNow = writeLoad & pendValid_r;

    // Burst addresses: second word flips bit zero
    wire [ADDR_W-1:0] rdAddr0 = {link.addressIn, link.addressBitZero}; // R6
    wire [ADDR_W-1:0] rdAddr1 = {link.addressIn, ~link.addressBitZero}; // R14
    wire [ADDR_W-1:0] pendAddr0 = {pendHi_r, pendB0_r};
    wire [ADDR_W-1:0] pendAddr1 = {pendHi_r, ~pendB0_r}; // R14

    // Coherency: compare upper bits against the held write
    wire pendHit = pendValid_r & (pendHi_r == link.addressIn); // R15
    wire sameB0 = pendB0_r == link.addressBitZero;
    wire [DATA_W-1:0] pendForRd0 = sameB0 ? pendWord0_r : pendWord1_r;
    wire [DATA_W-1:0] pendForRd1 = sameB0 ? pendWord1_r : pendWord0_r;
    wire [LANES-1:0] laneForRd0 = sameB0 ? pendLane0_r : pendLane1_r;
    wire [LANES-1:0] laneForRd1 = sameB0 ? pendLane1_r : pendLane0_r;
    wire [LANES-1:0] noLanes = '1;
    wire [DATA_W-1:0] rdWord0 = mergeLanes(memArray[rdAddr0], pendForRd0,
                                           pendHit ? laneForRd0 : noLanes); // R15
    wire [DATA_W-1:0] rdWord1 = mergeLanes(memArray[rdAddr1], pendForRd1,
                                           pendHit ? laneForRd1 : noLanes); // R15

    // Pin history for edge detection
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            kTruePrev_r <= 1'h1;
            kCompPrev_r <= 1'h1;
            cTruePrev_r <= 1'h1;
            cCompPrev_r <= 1'h1;
        end else begin
            kTruePrev_r <= link.kTrue;
            kCompPrev_r <= link.kComp;
            cTruePrev_r <= link.cTrue;
            cCompPrev_r <= link.cComp;
        end
    end

    // Array update: the older posted write retires when a new write loads
    always_ff @(posedge clock) begin
        if (commitNow) begin
            memArray[pendAddr0] <= mergeLanes(memArray[pendAddr0], pendWord0_r,
                                              pendLane0_r); // R8
            memArray[pendAddr1] <= mergeLanes(memArray[pendAddr1], pendWord1_r,
                                              pendLane1_r); // R8 R4
        end
    end

    // Posted write capture, first word with the load, second on K#
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_r <= DSB_IDLE;
            pendValid_r <= 1'h0;
            pendHi_r <= '0;
            pendB0_r <= 1'h0;
            pendWord0_r <= '0;
            pendWord1_r <= '0;
            pendLane0_r <= '1;
            pendLane1_r <= '1;
        end else begin
            case (state_r)
                DSB_IDLE: begin
                    if (writeLoad) begin
                        pendHi_r <= link.addressIn; // R6
                        pendB0_r <= link.addressBitZero; // R6
                        pendWord0_r <= link.dq; // R2
                        pendLane0_r <= link.byteLaneWriteN; // R8 R9 R17
                        pendLane1_r <= '1;
                        pendValid_r <= 1'h1;
                        state_r <= DSB_WR_SECOND;
                    end
                end
                DSB_WR_SECOND: begin
                    // Address pins are not looked at here
                    if (kcRise) begin
                        pendWord1_r <= link.dq; // R2 R7
                        pendLane1_r <= link.byteLaneWriteN; // R8
                        state_r <= DSB_IDLE; // R4
                    end
                end
                default: state_r <= DSB_IDLE;
            endcase
        end
    end

    // Read pipeline: capture on K, launch on the selected output edges
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdHoldValid_r <= 1'h0;
            rdHold0_r <= '0;
            rdHold1_r <= '0;
            rdSecond_r <= '0;
            secondDue_r <= 1'h0;
            dqOut_r <= '0;
            dqOe_r <= 1'h0;
        end else begin
            if (outEdge0) begin
                dqOut_r <= rdHold0_r; // R11 R12
                dqOe_r <= rdHoldValid_r; // R18
                rdSecond_r <= rdHold1_r;
                secondDue_r <= rdHoldValid_r;
                rdHoldValid_r <= 1'h0;
            end else if (outEdge1 && secondDue_r) begin
                dqOut_r <= rdSecond_r; // R11 R12 R4
                secondDue_r <= 1'h0;
            end
            // A new capture overrides the clear above
            if (readLoad) begin
                rdHoldValid_r <= 1'h1;
                rdHold0_r <= rdWord0;
                rdHold1_r <= rdWord1;
            end
        end
    end

    // Echo clocks follow whichever pair times the data
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            echoTrue_r <= 1'h0;
            echoComp_r <= 1'h1;
            busy_r <= 1'h0;
        end else begin
            echoTrue_r <= useInClk ? link.kTrue : link.cTrue;
            echoComp_r <= useInClk ? link.kComp : link.cComp;
            busy_r <= (state_r != DSB_IDLE) | rdHoldValid_r | dqOe_r;
        end
    end

    assign link.deviceDq = dqOut_r;
    assign link.deviceDqOe = dqOe_r;
    assign link.echoClockTrue = echoTrue_r;
    assign link.echoClockComp = echoComp_r;
    assign burstBusy = busy_r;
endmodule

// ---- dsb_bus_master.sv ----
// Master end: clock pair generation, command issue and read buffering
`timescale 1ns/100ps
module dsb_bus_master #(
    parameter int   DATA_W      = dsb_pkg::DEF_DATA_W,
    parameter int   ADDR_W      = dsb_pkg::DEF_ADDR_W,
    parameter int   BUF_DEPTH   = dsb_pkg::RD_BUF_DEPTH,
    parameter logic USE_OUT_CLK = 1'h1
) (
    input  wire logic                     clock,
    input  wire logic                     reset,
    dsb_link_if.master                    link,
    input  wire logic                     cmdValid,
    input  wire logic                     cmdRead,
    input  wire logic [ADDR_W-1:0]        cmdAddr,
    input  wire logic [DATA_W-1:0]        cmdWord0,
    input  wire logic [DATA_W-1:0]        cmdWord1,
    input  wire logic [DATA_W/9-1:0]      cmdLaneN0,
    input  wire logic [DATA_W/9-1:0]      cmdLaneN1,
    output logic                          cmdReady,
    output logic                          rdValid,
    output logic [DATA_W-1:0]             rdData,
    input  wire logic                     rdReady
);
    import dsb_pkg::*;

    localparam int LANES = DATA_W / LANE_W;
    localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int CNT_W = $clog2(BUF_DEPTH + 1);

    typedef enum logic {DSB_M_IDLE, DSB_M_SECOND} dsb_master_e;

    dsb_master_e            state_r;
    logic                   kTrue_r;
    logic                   kComp_r;
    logic                   loadN_r;
    logic                   rwSel_r;
    logic [ADDR_W-1:0]      addr_r;
    logic [LANES-1:0]       laneN_r;
    logic [DATA_W-1:0]      dqOut_r;
    logic                   dqOe_r;
    logic [DATA_W-1:0]      word1_r;
    logic [LANES-1:0]       lane1_r;
    logic                   cTrue_r;
    logic                   cComp_r;
    logic                   cmdReady_r;
    logic [RD_PIPE_LEN-1:0] rdPipe_r;
    logic [DATA_W-1:0]      bufMem [BUF_DEPTH];
    logic [PTR_W-1:0]       wrPtr_r;
    logic [PTR_W-1:0]       rdPtr_r;
    logic [CNT_W-1:0]       count_r;
    logic                   rdValid_r;
    logic [DATA_W-1:0]      rdData_r;

    // Command acceptance and read-return slots
    wire take = cmdValid & cmdReady_r;
    wire takeRead = take & cmdRead;
    wire inFlight = |rdPipe_r;
    wire push = rdPipe_r[RD_FIRST_SLOT] | rdPipe_r[RD_FIRST_SLOT+1];
    wire pop = rdValid_r & rdReady;
    // Ready only ahead of a true edge, with no read in flight and room for two
    wire readyNxt = kTrue_r & ~take & ~inFlight & (count_r == '0); // R16

    // Buffer pointer and count updates
    wire [PTR_W-1:0] wrPtrNxt = push ? PTR_W'((wrPtr_r + 1'h1) % BUF_DEPTH) : wrPtr_r;
    wire [PTR_W-1:0] rdPtrNxt = pop ? PTR_W'((rdPtr_r + 1'h1) % BUF_DEPTH) : rdPtr_r;
    wire [CNT_W-1:0] countNxt = CNT_W'(count_r + push - pop);
    wire bypassHead = push & (wrPtr_r == rdPtrNxt);
    wire [DATA_W-1:0] headNxt = bypassHead ? link.dq : bufMem[rdPtrNxt];

    // Pin sequencing: load with first word, second word half a period later
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_r <= DSB_M_IDLE;
            kTrue_r <= 1'h0;
            kComp_r <= 1'h1;
            loadN_r <= IDLE_LOAD_N;
            rwSel_r <= 1'h1;
            addr_r <= '0;
            laneN_r <= '1;
            dqOut_r <= '0;
            dqOe_r <= 1'h0;
            word1_r <= '0;
            lane1_r <= '1;
            cmdReady_r <= 1'h0;
        end else begin
            kTrue_r <= ~kTrue_r;
            // Own flop for the complement, so the pin has no gate behind it
            kComp_r <= kTrue_r;
            cmdReady_r <= readyNxt;
            case (state_r)
                DSB_M_IDLE: begin
                    loadN_r <= IDLE_LOAD_N; // R18
                    laneN_r <= '1;
                    dqOe_r <= 1'h0;
                    if (take) begin
                        loadN_r <= 1'h0; // R3
                        rwSel_r <= cmdRead; // R3 R5
                        addr_r <= cmdAddr; // R3
                        dqOut_r <= cmdWord0; // R2
                        dqOe_r <= ~cmdRead;
                        laneN_r <= cmdRead ? '1 : cmdLaneN0; // R8
                        word1_r <= cmdWord1;
                        lane1_r <= cmdRead ? '1 : cmdLaneN1;
                        state_r <= DSB_M_SECOND;
                    end
                end
                DSB_M_SECOND: begin
                    loadN_r <= IDLE_LOAD_N;
                    dqOut_r <= word1_r; // R2 R4
                    laneN_r <= lane1_r; // R8
                    state_r <= DSB_M_IDLE;
                end
                default: state_r <= DSB_M_IDLE;
            endcase
        end
    end

    // Output clock pair either mirrors K or is held high for good
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cTrue_r <= 1'h1;
            cComp_r <= 1'h1;
            rdPipe_r <= '0;
        end else begin
            cTrue_r <= USE_OUT_CLK ? ~kTrue_r : 1'h1; // R13
            cComp_r <= USE_OUT_CLK ? kTrue_r : 1'h1; // R13
            rdPipe_r <= {rdPipe_r[RD_PIPE_LEN-2:0], takeRead};
        end
    end

    // Read buffer storage; a stalled reader keeps both words
    always_ff @(posedge clock) begin
        if (push) begin
            bufMem[wrPtr_r] <= link.dq;
        end
    end

    // Buffer pointers and the registered head
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
            rdValid_r <= 1'h0;
            rdData_r <= '0;
        end else begin
            wrPtr_r <= wrPtrNxt;
            rdPtr_r <= rdPtrNxt;
            count_r <= countNxt;
            rdValid_r <= countNxt != '0;
            rdData_r <= headNxt;
        end
    end

    assign link.kTrue = kTrue_r;
    assign link.kComp = kComp_r;
    assign link.cTrue = cTrue_r;
    assign link.cComp = cComp_r;
    assign link.loadStrobeN = loadN_r;
    assign link.readWriteSel = rwSel_r;
    assign link.addressIn = addr_r[ADDR_W-1:1];
    assign link.addressBitZero = addr_r[0];
    assign link.byteLaneWriteN = laneN_r;
    assign link.masterDq = dqOut_r;
    assign link.masterDqOe = dqOe_r;
    assign cmdReady = cmdReady_r;
    assign rdValid = rdValid_r;
    assign rdData = rdData_r;
endmodule

// ---- dsb_link_checker.sv ----
// Protocol checker for the memory port link, watching the pins only
`timescale 1ns/100ps
module dsb_link_checker
    import dsb_pkg::*;
#(
    parameter int   DATA_W      = DEF_DATA_W,
    parameter logic USE_OUT_CLK = 1'h1
) (
    input wire logic                        clock,
    input wire logic                        reset,
    input wire logic                        kTrue,
    input wire logic                        kComp,
    input wire logic                        cTrue,
    input wire logic                        cComp,
    input wire logic                        loadStrobeN,
    input wire logic                        readWriteSel,
    input wire logic [DATA_W/LANE_W-1:0]    byteLaneWriteN,
    input wire logic                        masterDqOe,
    input wire logic                        deviceDqOe,
    input wire logic                        echoClockTrue
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // Decoded load kinds
    wire readLoad  = !loadStrobeN && readWriteSel;
    wire writeLoad = !loadStrobeN && !readWriteSel;

    property p_load_on_k;
        !loadStrobeN |-> kTrue;
    endproperty
    a_load_on_k: assert property (p_load_on_k) else $error("load outside K phase");
    property p_load_pulse;
        !loadStrobeN |=> loadStrobeN;
    endproperty
    a_load_pulse: assert property (p_load_pulse) else $error("load longer than one");
    property p_write_words;
        writeLoad |-> masterDqOe ##1 (masterDqOe && loadStrobeN) ##1 (!masterDqOe || !loadStrobeN);
    endproperty
    a_write_words: assert property (p_write_words) else $error("write not two words");
    // Read launch three cycles after load, two words, then release
    property p_read_words;
        readLoad |-> !masterDqOe ##3 deviceDqOe ##1 deviceDqOe ##1 !deviceDqOe;
    endproperty
    a_read_words: assert property (p_read_words) else $error("read burst timing");
    property p_read_cause;
        $rose(deviceDqOe) |-> $past(readLoad, 3);
    endproperty
    a_read_cause: assert property (p_read_cause) else $error("bus driven without read");
    property p_no_fight;
        deviceDqOe |-> !masterDqOe;
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("both ends drive data");
    property p_lanes_idle;
        !masterDqOe |-> &byteLaneWriteN;
    endproperty
    a_lanes_idle: assert property (p_lanes_idle) else $error("lane strobe outside write");
    // Skip the first edge after reset, where registers still hold reset values
    property p_k_pair;
        !$past(reset) |-> kComp == !kTrue && kTrue != $past(kTrue);
    endproperty
    a_k_pair: assert property (p_k_pair) else $error("input clock pair broken");
    property p_out_clk;
        !$past(reset) |-> (USE_OUT_CLK ? (cTrue == kTrue && cComp == kComp) : (cTrue && cComp));
    endproperty
    a_out_clk: assert property (p_out_clk) else $error("output clock pair wrong");
    property p_echo;
        !$past(reset) |-> echoClockTrue == $past(kTrue);
    endproperty
    a_echo: assert property (p_echo) else $error("echo clock not delayed copy");

    c_write: cover property (writeLoad);
    c_read: cover property (readLoad ##3 deviceDqOe);
    c_partial: cover property (masterDqOe && !(&byteLaneWriteN) && |byteLaneWriteN);
endmodule

// ---- ddr_sram_burst2_port_bench.sv ----
// Self-checking bench joining the memory end to its bus master
`timescale 1ns/100ps
module ddr_sram_burst2_port_bench;
    import dsb_pkg::*;
    localparam int DW = DEF_DATA_W;
    localparam int AW = 6;
    localparam int LN = DW / LANE_W;
    logic          clock;
    logic          reset;
    logic          cmdValid;
    logic          cmdRead;
    logic [AW-1:0] cmdAddr;
    logic [DW-1:0] cmdWord0;
    logic [DW-1:0] cmdWord1;
    logic [LN-1:0] cmdLaneN0;
    logic [LN-1:0] cmdLaneN1;
    logic          cmdReady;
    logic          rdValid;
    logic [DW-1:0] rdData;
    logic [DW-1:0] rdDataK;
    logic          rdReady;
    logic          burstBusy;
    logic [DW-1:0] model [2**AW];
    int            errors;
    int            comparisons;
    int            cycles;

    dsb_link_if #(.DATA_W(DW), .ADDR_W(AW)) dsb_link_if_i ();
    dsb_bus_master #(.DATA_W(DW), .ADDR_W(AW), .USE_OUT_CLK(1'h1)) dsb_bus_master_i (
        .clock(clock), .reset(reset), .link(dsb_link_if_i), .cmdValid(cmdValid),
        .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdWord0(cmdWord0), .cmdWord1(cmdWord1),
        .cmdLaneN0(cmdLaneN0), .cmdLaneN1(cmdLaneN1), .cmdReady(cmdReady),
        .rdValid(rdValid), .rdData(rdData), .rdReady(rdReady));
    dsb_sram_device #(.DATA_W(DW), .ADDR_W(AW)) dsb_sram_device_i (
        .clock(clock), .reset(reset), .link(dsb_link_if_i), .burstBusy(burstBusy));
    // Second pair with output clocks tied high, in lockstep with the first
    dsb_link_if #(.DATA_W(DW), .ADDR_W(AW)) dsb_link_if_k ();
    dsb_bus_master #(.DATA_W(DW), .ADDR_W(AW), .USE_OUT_CLK(1'h0)) dsb_bus_master_k_i (
        .clock(clock), .reset(reset), .link(dsb_link_if_k), .cmdValid(cmdValid),
        .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdWord0(cmdWord0), .cmdWord1(cmdWord1),
        .cmdLaneN0(cmdLaneN0), .cmdLaneN1(cmdLaneN1), .cmdReady(),
        .rdValid(), .rdData(rdDataK), .rdReady(rdReady));
    dsb_sram_device #(.DATA_W(DW), .ADDR_W(AW)) dsb_sram_device_k_i (
        .clock(clock), .reset(reset), .link(dsb_link_if_k), .burstBusy());
    dsb_link_checker #(.DATA_W(DW), .USE_OUT_CLK(1'h1)) dsb_link_checker_i (
        .clock(clock), .reset(reset), .kTrue(dsb_link_if_i.kTrue),
        .kComp(dsb_link_if_i.kComp), .cTrue(dsb_link_if_i.cTrue), .cComp(dsb_link_if_i.cComp),
        .loadStrobeN(dsb_link_if_i.loadStrobeN), .readWriteSel(dsb_link_if_i.readWriteSel),
        .byteLaneWriteN(dsb_link_if_i.byteLaneWriteN), .masterDqOe(dsb_link_if_i.masterDqOe),
        .deviceDqOe(dsb_link_if_i.deviceDqOe), .echoClockTrue(dsb_link_if_i.echoClockTrue));

    // Free-running system clock
    always #(CLK_PERIOD_NS / 2) clock = ~clock;

    // Hang guard, well above the few hundred cycles the scenarios need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] expd, input string what);
        comparisons++;
        if (seen !== expd) begin
            errors++;
            $display("MISMATCH %0t %s: seen %h expected %h", $time, what, seen, expd);
        end
    endtask

    // Lane merge done here independently, a low strobe takes the new lane
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] nw,
                                            input logic [LN-1:0] laneN);
        merge = old;
        for (int i = 0; i < LN; i++) begin
            if (!laneN[i]) begin
                merge[i*LANE_W +: LANE_W] = nw[i*LANE_W +: LANE_W];
            end
        end
    endfunction

    // One user command, held until taken; writes update the model
    task automatic issue(input logic rd, input logic [AW-1:0] a, input logic [DW-1:0] w0,
                         input logic [DW-1:0] w1, input logic [LN-1:0] l0, input logic [LN-1:0] l1);
        int n;
        n = 0;
        @(negedge clock);
        cmdValid = 1'h1;
        cmdRead = rd;
        cmdAddr = a;
        cmdWord0 = w0;
        cmdWord1 = w1;
        cmdLaneN0 = l0;
        cmdLaneN1 = l1;
        // Ready is looked at mid-cycle, the take happens at the next rising edge
        while (cmdReady !== 1'h1 && n < 100) begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
        check(DW'(n < 100), DW'(1), "command not taken");
        if (!rd) begin
            model[a] = merge(model[a], w0, l0);
            model[{a[AW-1:1], ~a[0]}] = merge(model[{a[AW-1:1], ~a[0]}], w1, l1);
        end
        @(negedge clock);
        cmdValid = 1'h0;
    endtask

    // Collect both read words in burst order and compare with the model
    task automatic collect(input logic [AW-1:0] a, input string what);
        logic [DW-1:0] expd [2];
        int n;
        expd[0] = model[a];
        expd[1] = model[{a[AW-1:1], ~a[0]}];
        for (int k = 0; k < 2; k++) begin
            n = 0;
            // Sampled mid-cycle while the word stands; the pop is the next edge
            while (!(rdValid === 1'h1 && rdReady === 1'h1) && n < 100) begin
                @(negedge clock);
                n++;
            end
            check(rdData, expd[k], what);
            check(rdDataK, expd[k], what);
            @(negedge clock);
        end
    endtask

    task automatic s_idle();
        repeat (6) begin
            @(negedge clock);
            check(dsb_link_if_i.dq, '0, "idle bus driven");
            check(DW'(burstBusy), '0, "busy while idle");
        end
    endtask

    // Even and odd start addresses, bypass of posted write, then retire
    task automatic s_burst();
        issue(1'h0, 6'h04, 18'h12345, 18'h2abcd, 2'h0, 2'h0);
        issue(1'h1, 6'h04, '0, '0, 2'h3, 2'h3);
        collect(6'h04, "bypass read");
        issue(1'h1, 6'h05, '0, '0, 2'h3, 2'h3);
        collect(6'h05, "odd start order");
        issue(1'h0, 6'h09, 18'h0f0f0, 18'h30303, 2'h0, 2'h0);
        issue(1'h1, 6'h04, '0, '0, 2'h3, 2'h3);
        collect(6'h04, "array read");
        issue(1'h1, 6'h09, '0, '0, 2'h3, 2'h3);
        collect(6'h09, "odd write order");
    endtask

    // Every lane strobe code on both words, read back held then retired
    task automatic s_lanes();
        for (int m = 0; m < 4; m++) begin
            issue(1'h0, 6'h10, 18'h3ffff, 18'h00000, 2'h0, 2'h0);
            issue(1'h0, 6'h10, 18'h155aa, 18'h2aa55, LN'(m), LN'(3 - m));
            issue(1'h1, 6'h10, '0, '0, 2'h3, 2'h3);
            collect(6'h10, "lane merge held");
            issue(1'h0, 6'h20, 18'h01234, 18'h04321, 2'h0, 2'h0);
            issue(1'h1, 6'h10, '0, '0, 2'h3, 2'h3);
            collect(6'h10, "lane merge array");
        end
    endtask

    // Receiver stalls: buffer holds the burst and new commands are refused
    task automatic s_stall();
        @(negedge clock);
        rdReady = 1'h0;
        issue(1'h1, 6'h04, '0, '0, 2'h3, 2'h3);
        repeat (12) begin
            @(negedge clock);
            check(DW'(cmdReady), '0, "ready during stall");
        end
        check(DW'(rdValid), DW'(1), "buffered read lost");
        @(negedge clock);
        rdReady = 1'h1;
        collect(6'h04, "stalled read");
    endtask

    initial begin
        clock = 1'h0;
        reset = 1'h1;
        cmdValid = 1'h0;
        cmdRead = 1'h0;
        cmdAddr = '0;
        cmdWord0 = '0;
        cmdWord1 = '0;
        cmdLaneN0 = '1;
        cmdLaneN1 = '1;
        rdReady = 1'h1;
        errors = 0;
        comparisons = 0;
        cycles = 0;
        repeat (20) @(posedge clock);
        @(negedge clock);
        reset = 1'h0;
        s_idle();
        s_burst();
        s_lanes();
        s_stall();
        print_verdict();
    end
endmodule
